// *** src/cky_pkg.sv ***
package cky_pkg;
   localparam int unsigned CKY_VEC_W = 53;
   localparam int unsigned CKY_APB_AW = 8;
   localparam logic [7:0] CKY_ADDR_CTRL = 8'h00;
   localparam logic [7:0] CKY_ADDR_CUSTOM0 = 8'h04;
   localparam logic [7:0] CKY_ADDR_CUSTOM1 = 8'h08;
   localparam logic [7:0] CKY_ADDR_CUSTOM2 = 8'h0c;
   localparam logic [7:0] CKY_ADDR_STATUS = 8'h10;
   localparam int unsigned CKY_CTRL_USE_CL = 0;
   localparam int unsigned CKY_CTRL_MASQ_ENA = 1;
   localparam int unsigned CKY_CTRL_HOST_ENA = 2;
   localparam int unsigned CKY_CTRL_VDEV_ENA = 3;
   localparam int unsigned CKY_CTRL_LBK3_ENA = 4;
   localparam logic [4:0] CKY_CTRL_RESET = 5'h00;
   localparam logic [15:0] CKY_CUSTOM_RESET = 16'h0000;
   localparam logic [15:0] CKY_TPID_CTAG = 16'h8100;
   localparam logic [15:0] CKY_TPID_STAG = 16'h88a8;
   localparam logic [2:0] CKY_CODE_NONE = 3'h0;
   localparam logic [2:0] CKY_CODE_CTAG = 3'h1;
   localparam logic [2:0] CKY_CODE_STAG = 3'h4;
   localparam logic [2:0] CKY_CODE_CUSTOM0 = 3'h5;
   localparam logic [1:0] CKY_SEL_PHYS = 2'h0;
   localparam logic [1:0] CKY_SEL_LOOP = 2'h1;
   localparam logic [1:0] CKY_SEL_MASQ = 2'h2;
   localparam logic [1:0] CKY_SEL_FLAGS = 2'h3;
   localparam int unsigned CKY_F_HOST0 = 0;
   localparam int unsigned CKY_F_HOST1 = 1;
   localparam int unsigned CKY_F_VDEV0 = 2;
   localparam int unsigned CKY_F_VDEV1 = 3;
   localparam int unsigned CKY_F_SRC_LO = 4;
   localparam int unsigned CKY_F_PT_LO = 44;
   localparam int unsigned CKY_F_ACT_LO = 49;
   localparam int unsigned CKY_F_RSVD = 52;
   localparam int unsigned CKY_MAC_GROUP_BIT = 40;
   localparam logic [15:0] CKY_ETYPE_MIN = 16'h0600;
   localparam logic [3:0] CKY_IP4_MC_NIBBLE = 4'he;
   localparam logic [7:0] CKY_IP6_MC_OCTET = 8'hff;
   localparam logic [5:0] CKY_HOST0_PORT = 6'h35;
   localparam logic [5:0] CKY_HOST1_PORT = 6'h36;
   localparam logic [5:0] CKY_VDEV0_PORT = 6'h37;
   localparam logic [5:0] CKY_VDEV1_PORT = 6'h38;
   localparam logic [2:0] CKY_ACT_INJ_MASQ = 3'h1;

   typedef struct packed {
      logic present;
      logic [15:0] tpid;
      logic [15:0] tci;
   } cky_tag_s;

   typedef struct packed {
      logic [5:0] phys_port;
      logic [5:0] src_port;
      logic [5:0] loop_port;
      logic from_loopback;
      logic injected;
      logic [4:0] pipeline_point;
      logic [2:0] pipeline_action;
      logic [47:0] dmac;
      cky_tag_s [2:0] tags;
      logic [2:0] cl_pcp;
      logic cl_dei;
      logic [11:0] cl_vid;
      logic is_ipv4;
      logic is_ipv6;
      logic [7:0] dip_top;
      logic [15:0] type_len;
   } cky_frame_s;

   typedef struct packed {
      logic [2:0] code;
      logic [2:0] pcp;
      logic dei;
      logic [11:0] vid;
   } cky_tagkey_s;

   typedef struct packed {
      logic [1:0] ingress_vector_selector;
      logic [CKY_VEC_W-1:0] ingress_port_vector;
      logic dest_group_flag;
      logic dest_broadcast_flag;
      cky_tagkey_s [2:0] tag_keys;
      logic ip_group_flag;
      logic type_encoded_flag;
   } cky_key_s;
endpackage : cky_pkg

// *** src/cky_tag_code.sv ***
module cky_tag_code
   import cky_pkg::*;
(
   // Parsed tag.
   input wire cky_tag_s tag,
   // Custom identifiers.
   input wire logic [2:0][15:0] custom,
   // Key fields.
   output cky_tagkey_s fields
);
   always_comb
   begin
      fields.code = CKY_CODE_NONE;
      if (tag.present)
      begin
         if (tag.tpid == CKY_TPID_CTAG)
            fields.code = CKY_CODE_CTAG;
         else if (tag.tpid == CKY_TPID_STAG)
            fields.code = CKY_CODE_STAG;
         else if (tag.tpid == custom[0])
            fields.code = CKY_CODE_CUSTOM0;
         else if (tag.tpid == custom[1])
            fields.code = CKY_CODE_CUSTOM0 + 3'h1;
         else if (tag.tpid == custom[2])
            fields.code = CKY_CODE_CUSTOM0 + 3'h2;
      end
      fields.pcp = tag.tci[15:13];
      fields.dei = tag.tci[12];
      fields.vid = tag.tci[11:0];
   end
endmodule : cky_tag_code

// *** src/cky_key_builder.sv ***
module cky_key_builder
   import cky_pkg::*;
#(
   parameter logic [5:0] HOST0_PORT = CKY_HOST0_PORT,
   parameter logic [5:0] HOST1_PORT = CKY_HOST1_PORT,
   parameter logic [5:0] VDEV0_PORT = CKY_VDEV0_PORT,
   parameter logic [5:0] VDEV1_PORT = CKY_VDEV1_PORT,
   parameter logic [2:0] ACT_INJ_MASQ = CKY_ACT_INJ_MASQ
)
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [CKY_APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Parse results from the analyzer.
   input wire logic frame_valid,
   input wire cky_frame_s frame,
   // Key to the lookup.
   output logic key_valid,
   output cky_key_s key
);
   logic [4:0] ctrl_reg;
   logic [2:0][15:0] custom_reg;
   logic [15:0] key_count_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic snap_valid_reg;
   cky_frame_s snap_reg;
   logic key_valid_reg;
   cky_key_s key_reg;
   cky_key_s key_next;
   cky_tagkey_s [2:0] tag_fields;
   logic sel3_hit;
   logic masq_hit;
   logic apb_write;
   logic addr_ok;

   function automatic logic [CKY_VEC_W-1:0] port_onehot(input logic [5:0] port);
      logic [CKY_VEC_W-1:0] v;
      v = '0;
      if (int'(port) < CKY_VEC_W)
         v[port] = 1'b1;
      return v;
   endfunction : port_onehot

   function automatic logic known_addr(input logic [CKY_APB_AW-1:0] a);
      return a == CKY_ADDR_CTRL || a == CKY_ADDR_CUSTOM0 || a == CKY_ADDR_CUSTOM1 ||
         a == CKY_ADDR_CUSTOM2 || a == CKY_ADDR_STATUS;
   endfunction : known_addr

   assign addr_ok = known_addr(paddr);
   assign apb_write = psel && penable && pready_reg && pwrite && addr_ok;

   // Zero wait states: the answer is ready in the first access cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end
      else
      begin
         pready_reg <= psel && !penable;
         pslverr_reg <= psel && !penable && !addr_ok;
         prdata_reg <= 32'h0000_0000;
         if (psel && !penable && !pwrite)
         begin
            case (paddr)
               CKY_ADDR_CTRL: prdata_reg <= {27'h0000000, ctrl_reg};
               CKY_ADDR_CUSTOM0: prdata_reg <= {16'h0000, custom_reg[0]};
               CKY_ADDR_CUSTOM1: prdata_reg <= {16'h0000, custom_reg[1]};
               CKY_ADDR_CUSTOM2: prdata_reg <= {16'h0000, custom_reg[2]};
               CKY_ADDR_STATUS: prdata_reg <= {14'h0000, key_reg.ingress_vector_selector, key_count_reg};
               default: prdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= CKY_CTRL_RESET;
         custom_reg <= {3{CKY_CUSTOM_RESET}};
      end
      else if (apb_write)
      begin
         case (paddr)
            CKY_ADDR_CTRL: ctrl_reg <= pwdata[4:0];
            CKY_ADDR_CUSTOM0: custom_reg[0] <= pwdata[15:0];
            CKY_ADDR_CUSTOM1: custom_reg[1] <= pwdata[15:0];
            CKY_ADDR_CUSTOM2: custom_reg[2] <= pwdata[15:0];
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // The snapshot keeps later parse updates from mixing into a key in flight.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         snap_valid_reg <= 1'b0;
         snap_reg <= '0;
      end
      else
      begin
         snap_valid_reg <= frame_valid;
         if (frame_valid)
            snap_reg <= frame;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_tag
         cky_tag_code u_tag (
            .tag(snap_reg.tags[gi]),
            .custom(custom_reg),
            .fields(tag_fields[gi])
         );
      end
   endgenerate

   assign masq_hit = ctrl_reg[CKY_CTRL_MASQ_ENA] &&
      ((snap_reg.injected && snap_reg.src_port != snap_reg.phys_port) ||
      snap_reg.pipeline_action == ACT_INJ_MASQ);
   assign sel3_hit = (ctrl_reg[CKY_CTRL_HOST_ENA] && snap_reg.injected) ||
      (ctrl_reg[CKY_CTRL_VDEV_ENA] && (snap_reg.phys_port == VDEV0_PORT || snap_reg.phys_port == VDEV1_PORT)) ||
      (ctrl_reg[CKY_CTRL_LBK3_ENA] && snap_reg.from_loopback);

   always_comb
   begin
      key_next = '0;
      if (sel3_hit)
      begin
         key_next.ingress_vector_selector = CKY_SEL_FLAGS;
         key_next.ingress_port_vector[CKY_F_HOST0] = snap_reg.phys_port == HOST0_PORT;
         key_next.ingress_port_vector[CKY_F_HOST1] = snap_reg.phys_port == HOST1_PORT;
         key_next.ingress_port_vector[CKY_F_VDEV0] = snap_reg.phys_port == VDEV0_PORT;
         key_next.ingress_port_vector[CKY_F_VDEV1] = snap_reg.phys_port == VDEV1_PORT;
         key_next.ingress_port_vector[CKY_F_SRC_LO +: 6] = snap_reg.src_port;
         key_next.ingress_port_vector[CKY_F_PT_LO +: 5] = snap_reg.pipeline_point;
         key_next.ingress_port_vector[CKY_F_ACT_LO +: 3] = snap_reg.pipeline_action;
         key_next.ingress_port_vector[CKY_F_RSVD] = 1'b0;
      end
      else if (masq_hit)
      begin
         key_next.ingress_vector_selector = CKY_SEL_MASQ;
         key_next.ingress_port_vector = port_onehot(snap_reg.src_port);
      end
      else if (snap_reg.from_loopback)
      begin
         key_next.ingress_vector_selector = CKY_SEL_LOOP;
         key_next.ingress_port_vector = port_onehot(snap_reg.loop_port);
      end
      else
      begin
         key_next.ingress_vector_selector = CKY_SEL_PHYS;
         key_next.ingress_port_vector = port_onehot(snap_reg.phys_port);
      end
      key_next.dest_group_flag = snap_reg.dmac[CKY_MAC_GROUP_BIT];
      key_next.dest_broadcast_flag = &snap_reg.dmac;
      key_next.tag_keys = tag_fields;
      if (ctrl_reg[CKY_CTRL_USE_CL])
      begin
         key_next.tag_keys[0].pcp = snap_reg.cl_pcp;
         key_next.tag_keys[0].dei = snap_reg.cl_dei;
         key_next.tag_keys[0].vid = snap_reg.cl_vid;
      end
      if (!snap_reg.tags[0].present)
         key_next.tag_keys[0].vid = 12'h000;
      key_next.ip_group_flag = (snap_reg.is_ipv4 && snap_reg.dip_top[7:4] == CKY_IP4_MC_NIBBLE) ||
         (snap_reg.is_ipv6 && snap_reg.dip_top == CKY_IP6_MC_OCTET);
      key_next.type_encoded_flag = snap_reg.type_len >= CKY_ETYPE_MIN;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         key_valid_reg <= 1'b0;
         key_reg <= '0;
      end
      else
      begin
         key_valid_reg <= snap_valid_reg;
         if (snap_valid_reg)
            key_reg <= key_next;
      end
   end

   // The counter wraps; software reads it only as a liveness indication.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         key_count_reg <= 16'h0000;
      else if (snap_valid_reg)
         key_count_reg <= key_count_reg + 16'h0001;
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign key_valid = key_valid_reg;
   assign key = key_reg;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_frame_in;
      frame_valid ##1 snap_valid_reg;
   endsequence

   sequence s_apb_setup;
      psel && !penable;
   endsequence

   property p_snapshot_latency;
      s_frame_in |=> key_valid_reg;
   endproperty
   a_snapshot_latency: assert property (p_snapshot_latency) else $error("key not presented after snapshot");

   property p_key_from_input;
      frame_valid |-> ##2 key_reg.dest_group_flag == $past(frame.dmac[CKY_MAC_GROUP_BIT], 2);
   endproperty
   a_key_from_input: assert property (p_key_from_input) else $error("group flag not from frame");

   property p_broadcast;
      key_valid_reg |-> key_reg.dest_broadcast_flag == (&$past(snap_reg.dmac));
   endproperty
   a_broadcast: assert property (p_broadcast) else $error("broadcast flag wrong");

   property p_untagged_vid;
      key_valid_reg && !$past(snap_reg.tags[0].present) |-> key_reg.tag_keys[0].vid == 12'h000 &&
         key_reg.tag_keys[0].code == CKY_CODE_NONE;
   endproperty
   a_untagged_vid: assert property (p_untagged_vid) else $error("untagged frame gave nonzero outer vid");

   property p_type_encoded;
      key_valid_reg |-> key_reg.type_encoded_flag == ($past(snap_reg.type_len) >= CKY_ETYPE_MIN);
   endproperty
   a_type_encoded: assert property (p_type_encoded) else $error("type encoded flag wrong");

   property p_sel_priority;
      snap_valid_reg && sel3_hit |=> key_reg.ingress_vector_selector == CKY_SEL_FLAGS;
   endproperty
   a_sel_priority: assert property (p_sel_priority) else $error("selector 3 not preferred");

   property p_sel_phys;
      key_valid_reg && key_reg.ingress_vector_selector == CKY_SEL_PHYS |->
         key_reg.ingress_port_vector == port_onehot($past(snap_reg.phys_port));
   endproperty
   a_sel_phys: assert property (p_sel_phys) else $error("physical port vector wrong");

   property p_sel_loop;
      key_valid_reg && key_reg.ingress_vector_selector == CKY_SEL_LOOP |->
         key_reg.ingress_port_vector == port_onehot($past(snap_reg.loop_port));
   endproperty
   a_sel_loop: assert property (p_sel_loop) else $error("loopback port vector wrong");

   property p_sel_masq;
      key_valid_reg && key_reg.ingress_vector_selector == CKY_SEL_MASQ |->
         key_reg.ingress_port_vector == port_onehot($past(snap_reg.src_port));
   endproperty
   a_sel_masq: assert property (p_sel_masq) else $error("masquerade port vector wrong");

   // Classified values replace the outer tag fields; without that tag the pcp and dei are still replaced and the vid is zero.
   property p_classified;
      key_valid_reg && $past(ctrl_reg[CKY_CTRL_USE_CL]) && $past(snap_reg.tags[0].present) |->
         key_reg.tag_keys[0].vid == $past(snap_reg.cl_vid) &&
         key_reg.tag_keys[0].pcp == $past(snap_reg.cl_pcp) &&
         key_reg.tag_keys[0].dei == $past(snap_reg.cl_dei);
   endproperty
   a_classified: assert property (p_classified) else $error("classified outer tag fields not used");

   property p_sel_flags;
      key_valid_reg && key_reg.ingress_vector_selector == CKY_SEL_FLAGS |->
         !key_reg.ingress_port_vector[CKY_F_RSVD] && key_reg.ingress_port_vector[9:4] == $past(snap_reg.src_port);
   endproperty
   a_sel_flags: assert property (p_sel_flags) else $error("selector 3 layout wrong");

   property p_ip_group;
      key_valid_reg && $past(snap_reg.is_ipv6) && $past(snap_reg.dip_top) == CKY_IP6_MC_OCTET |->
         key_reg.ip_group_flag;
   endproperty
   a_ip_group: assert property (p_ip_group) else $error("ipv6 group flag missing");

   property p_apb_answer;
      s_apb_setup |=> pready_reg;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");
endmodule : cky_key_builder

// *** bench/cky_analyzer_model.sv ***
module cky_analyzer_model
   import cky_pkg::*;
(
   // Clock.
   input wire logic pclk,
   // Parse results towards the key builder.
   output logic frame_valid,
   output cky_frame_s frame
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      frame_valid = 1'b0;
      frame = '0;
   end

   // After the pulse the bus shows the inverse, so a late sample cannot match by chance.
   task push(input cky_frame_s fr);
      @(posedge pclk);
      frame_valid <= 1'b1;
      frame <= fr;
      @(posedge pclk);
      frame_valid <= 1'b0;
      frame <= ~fr;
   endtask : push
endmodule : cky_analyzer_model

// *** bench/cky_key_builder_tb.sv ***
module cky_key_builder_tb;
   import cky_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [CKY_APB_AW-1:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic frame_valid;
   cky_frame_s frame;
   logic key_valid;
   cky_key_s key;
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic err;
   cky_frame_s f;
   logic [52:0] vec;
   logic [5:0] pp [5] = '{CKY_HOST0_PORT, CKY_HOST1_PORT, CKY_VDEV0_PORT, CKY_VDEV1_PORT, 6'h10};

   cky_key_builder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_valid(frame_valid), .frame(frame), .key_valid(key_valid), .key(key));
   cky_analyzer_model u_far (.pclk(pclk), .frame_valid(frame_valid), .frame(frame));

   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task test_done;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   // A hung handshake must still end the run with a verdict.
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         test_done;
      end
   end

   task check(input logic [127:0] seen, input logic [127:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         miscompares++;
      end
   endtask : check

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic cky_tagkey_s tk(input logic [2:0] c, input logic [15:0] t);
      return {c, t[15:13], t[12], t[11:0]};
   endfunction : tk

   function automatic cky_tag_s tg(input logic [15:0] p, input logic [15:0] t);
      return {1'b1, p, t};
   endfunction : tg

   task run(input cky_frame_s fr, input cky_key_s ex);
      u_far.push(fr);
      @(posedge pclk);
      #1;
      check(key_valid, 1'b1);
      check(key, ex);
      @(posedge pclk);
      #1;
      check(key_valid, 1'b0);
   endtask : run

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CKY_ADDR_CTRL, 32'h0, rd, err);
      check(rd, 32'h0);
      apb(1'b0, CKY_ADDR_CUSTOM0, 32'h0, rd, err);
      check(rd, 32'h0);
      apb(1'b1, CKY_ADDR_CUSTOM0, 32'h9100, rd, err);
      apb(1'b1, CKY_ADDR_CUSTOM1, 32'h9200, rd, err);
      apb(1'b1, CKY_ADDR_CUSTOM2, 32'h9300, rd, err);
      apb(1'b0, CKY_ADDR_CUSTOM2, 32'h0, rd, err);
      check(rd, 32'h9300);
      apb(1'b0, 8'h14, 32'h0, rd, err);
      check({err, rd}, {1'b1, 32'h0});
      $display("test registers done");
      f = '0;
      f.phys_port = 6'h05;
      f.tags[0] = tg(CKY_TPID_CTAG, 16'ha123);
      f.tags[1] = tg(CKY_TPID_STAG, 16'h3456);
      f.tags[2] = tg(16'h9100, 16'he789);
      f.dmac = 48'hffffffffffff;
      f.is_ipv4 = 1'b1;
      f.dip_top = 8'he0;
      f.type_len = 16'h0600;
      f.cl_vid = 12'habc;
      run(f, {CKY_SEL_PHYS, 53'h1 << 5, 2'b11, tk(3'h5, 16'he789), tk(3'h4, 16'h3456), tk(3'h1, 16'ha123), 2'b11});
      apb(1'b1, CKY_ADDR_CTRL, 32'h1, rd, err);
      f = '0;
      f.phys_port = 6'h34;
      f.cl_pcp = 3'h3;
      f.cl_dei = 1'b1;
      f.cl_vid = 12'habc;
      f.dmac = 48'h010000000000;
      f.is_ipv6 = 1'b1;
      f.dip_top = 8'hff;
      f.type_len = 16'h05ff;
      f.tags[2] = tg(16'h9300, 16'h4567);
      f.tags[1] = tg(16'h1234, 16'h2001);
      run(f, {CKY_SEL_PHYS, 53'h1 << 52, 2'b10, tk(3'h7, 16'h4567), tk(3'h0, 16'h2001), tk(3'h0, 16'h7000), 2'b10});
      f.phys_port = 6'h02;
      f.from_loopback = 1'b1;
      f.loop_port = 6'h07;
      f.tags[0] = tg(CKY_TPID_STAG, 16'h0005);
      f.tags[2] = '0;
      f.tags[1] = tg(16'h9200, 16'hb234);
      f.dmac = 48'hfeffffffffff;
      f.is_ipv6 = 1'b0;
      f.is_ipv4 = 1'b1;
      f.dip_top = 8'hdf;
      f.type_len = 16'hffff;
      run(f, {CKY_SEL_LOOP, 53'h1 << 7, 2'b00, 19'h0, tk(3'h6, 16'hb234), tk(3'h4, 16'h7abc), 2'b01});
      $display("test fields done");
      apb(1'b1, CKY_ADDR_CTRL, 32'h2, rd, err);
      f = '0;
      f.phys_port = 6'h03;
      f.src_port = 6'h09;
      f.injected = 1'b1;
      f.from_loopback = 1'b1;
      f.loop_port = 6'h07;
      run(f, {CKY_SEL_MASQ, 53'h1 << 9, 61'h0});
      f.injected = 1'b0;
      f.src_port = 6'h0b;
      f.pipeline_action = CKY_ACT_INJ_MASQ;
      run(f, {CKY_SEL_MASQ, 53'h1 << 11, 61'h0});
      $display("test masquerade done");
      apb(1'b1, CKY_ADDR_CTRL, 32'h1e, rd, err);
      apb(1'b0, CKY_ADDR_CTRL, 32'h0, rd, err);
      check(rd, 32'h1e);
      for (int i = 0; i < 5; i++)
      begin
         f = '0;
         f.phys_port = pp[i];
         f.injected = (i < 2);
         f.from_loopback = (i == 4);
         f.loop_port = 6'h07;
         f.src_port = 6'h2a;
         f.pipeline_point = 5'h15;
         f.pipeline_action = 3'h6;
         vec = (i < 4) ? (53'h1 << i) : 53'h0;
         vec = vec | (53'h2a << 4) | (53'h15 << 44) | (53'h6 << 49);
         run(f, {CKY_SEL_FLAGS, vec, 61'h0});
      end
      apb(1'b0, CKY_ADDR_STATUS, 32'h0, rd, err);
      check({err, rd}, {1'b0, 32'h0003000a});
      $display("test flags done");
      test_done;
   end
endmodule : cky_key_builder_tb
